//--- hw/acs_pkg.sv
// Purpose: Shared constants for the converter sequencer.
// Assumes: 8-bit register port, one 50 MHz clock.
// Notes: Offsets are byte addresses on the register port.
package acs_pkg;
   localparam logic [7:0] ACS_OFF_CHSEL = 8'hBB;
   localparam logic [7:0] ACS_OFF_CFG = 8'hBC;
   localparam logic [7:0] ACS_OFF_RESULT = 8'hBE;
   localparam logic [7:0] ACS_OFF_CTRL = 8'hE8;
   localparam logic [7:0] ACS_OFF_INT_STAT = 8'hC0;
   localparam logic [7:0] ACS_OFF_INT_MASK = 8'hC1;
   // Control register fields.
   localparam int ACS_CTRL_EN_BIT = 7;
   localparam int ACS_CTRL_LPT_BIT = 6;
   localparam int ACS_CTRL_DONE_BIT = 5;
   localparam int ACS_CTRL_BUSY_BIT = 4;
   localparam int ACS_CTRL_SRC_LSB = 0;
   // Configuration register: divider in bits 7:3.
   localparam int ACS_CFG_DIV_LSB = 3;
   // Channel select: negative input in 7:4, GND when bit 7 is set.
   localparam int ACS_CHSEL_NEG_GND_BIT = 7;
   localparam logic [7:0] ACS_CHSEL_RESET = 8'h00;
   localparam logic [4:0] ACS_DIV_RESET = 5'h1F;
   localparam logic [2:0] ACS_SRC_RESET = 3'h0;
   localparam logic [7:0] ACS_MASK_RESET = 8'h00;
   localparam logic [7:0] ACS_SAR_MSB = 8'h80;
   localparam logic [1:0] ACS_TRACK_CLOCKS = 2'h3;
   localparam logic [2:0] ACS_SAR_BITS_M1 = 3'h7;
   typedef enum logic [2:0] {
      ACS_SRC_SW = 3'b000,
      ACS_SRC_T0 = 3'b001,
      ACS_SRC_T2 = 3'b010,
      ACS_SRC_T1 = 3'b011,
      ACS_SRC_EXT = 3'b100
   } acs_src_t;
   typedef enum logic [1:0] {
      ACS_ST_IDLE = 2'b00,
      ACS_ST_TRACK = 2'b01,
      ACS_ST_CONV = 2'b10
   } acs_state_t;
endpackage : acs_pkg

//--- hw/acs_sequencer.sv
// Purpose: Start selection, timing and register front end of an 8-bit SAR converter.
// Assumes: Timer overflows are one-cycle pulses on clk_in; the comparator answer
//    compare_in is settled against sar_trial_out within one clock.
// Notes: Register offsets and field positions live in the package.
// Notes on behaviour
// R1: conversion clock is system clock divided by divider field plus one, 0..31.
// R2: start source chosen by the start source select field of control.
// R3: software start by writing 1 to the in-progress bit.
// R4: Timer 0, Timer 2 and Timer 1 overflows are start sources.
// R5: external source starts on each rising edge of the external start input.
// R6: in-progress bit is 1 during conversion, cleared on completion.
// R7: falling edge of in-progress sets done flag and, if enabled, interrupt; a disable abort sets neither.
// R8: result register is valid whenever done flag reads 1.
// R9: software polls the done flag, not the in-progress bit.
// R10: Timer 2 low overflow in 8-bit mode, high overflow in 16-bit mode.
// R11: low-power track bit 0 tracks continuously except during conversion.
// R12: low-power track bit 1 tracks three conversion clocks after each start.
// R13: external start in low-power mode tracks while input low, converts on rise.
// R14: tracking may be switched off during standby or sleep.
// R15: software prefers low-power tracking when it changes input selections often.
// R16: software makes the crossbar skip the shared external start pin.
// R17: whole subsystem shut down unless converter enable is 1.
// R18: unsigned result with GND negative input, otherwise two's complement.
// R19: start events arriving while a conversion runs are ignored.
`timescale 1ns/1ps
module acs_sequencer (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic timer0_ovf_in,
   input wire logic timer1_ovf_in,
   input wire logic timer2_low_ovf_in,
   input wire logic timer2_high_ovf_in,
   input wire logic timer2_split_in,
   input wire logic external_start_input,
   input wire logic standby_in,
   input wire logic compare_in,
   output logic [7:0] rdata_out,
   output logic irq_out,
   output logic track_out,
   output logic power_on_out,
   output logic [7:0] sar_trial_out
);
   import acs_pkg::*;

   // The external start pin is asynchronous, so the first stage feeds only the second; the logic reads the second and third.
   logic ext_meta_reg;
   logic ext_sync_reg;
   logic ext_prev_reg;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         ext_meta_reg <= external_start_input;
         ext_sync_reg <= ext_meta_reg;
         ext_prev_reg <= ext_sync_reg;
      end
   end

   logic [7:0] chsel_reg, chsel_next;
   logic [4:0] div_reg, div_next;
   logic [4:0] cnt_reg, cnt_next;
   logic en_reg, en_next;
   logic lpt_reg, lpt_next;
   logic done_reg, done_next;
   logic busy_reg, busy_next;
   acs_src_t src_reg, src_next;
   acs_state_t state_reg, state_next;
   logic [1:0] trk_reg, trk_next;
   logic [2:0] bit_reg, bit_next;
   logic [7:0] trial_reg, trial_next;
   logic [7:0] result_reg, result_next;
   logic [7:0] istat_reg, istat_next;
   logic [7:0] mask_reg, mask_next;
   logic [7:0] rdata_next;
   logic irq_next;
   logic track_reg, track_next;
   logic ext_rise, t2_evt, start_evt, start_ok, tick, done_evt;
   logic [7:0] code_final, res_fmt;

   always_comb begin
      ext_rise = ext_sync_reg & ~ext_prev_reg; // R5
      t2_evt = timer2_split_in ? timer2_low_ovf_in : timer2_high_ovf_in; // R10
      case (src_reg) // R2 R4
         ACS_SRC_SW: start_evt = wr_in && (addr_in == ACS_OFF_CTRL)
            && wdata_in[ACS_CTRL_BUSY_BIT]; // R3
         ACS_SRC_T0: start_evt = timer0_ovf_in;
         ACS_SRC_T2: start_evt = t2_evt;
         ACS_SRC_T1: start_evt = timer1_ovf_in;
         ACS_SRC_EXT: start_evt = ext_rise;
         default: start_evt = 1'b0;
      endcase
      // A start is only taken while idle and enabled.
      start_ok = start_evt && !busy_reg && en_reg; // R19 R17
      tick = (cnt_reg == div_reg); // R1
      code_final = compare_in ? trial_reg : (trial_reg & ~(8'h01 << bit_reg));
      // The comparator gives offset binary; flipping the top bit makes it signed.
      res_fmt = chsel_reg[ACS_CHSEL_NEG_GND_BIT] ? code_final
         : {~code_final[7], code_final[6:0]}; // R18
      done_evt = (state_reg == ACS_ST_CONV) && tick && (bit_reg == 3'h0);
   end

   always_comb begin
      chsel_next = chsel_reg;
      div_next = div_reg;
      en_next = en_reg;
      lpt_next = lpt_reg;
      src_next = src_reg;
      done_next = done_reg;
      mask_next = mask_reg;
      istat_next = istat_reg;
      state_next = state_reg;
      busy_next = busy_reg;
      cnt_next = tick ? 5'h00 : cnt_reg + 5'h01;
      trk_next = trk_reg;
      bit_next = bit_reg;
      trial_next = trial_reg;
      result_next = result_reg;
      rdata_next = 8'h00;
      if (wr_in) begin
         case (addr_in)
            ACS_OFF_CHSEL: chsel_next = wdata_in;
            ACS_OFF_CFG: div_next = wdata_in[ACS_CFG_DIV_LSB +: 5];
            ACS_OFF_CTRL: begin
               en_next = wdata_in[ACS_CTRL_EN_BIT];
               lpt_next = wdata_in[ACS_CTRL_LPT_BIT];
               src_next = acs_src_t'(wdata_in[ACS_CTRL_SRC_LSB +: 3]);
               // Software may only clear the done flag, never set it.
               done_next = done_reg & wdata_in[ACS_CTRL_DONE_BIT];
            end
            ACS_OFF_INT_MASK: mask_next = wdata_in;
            default: ;
         endcase
      end
      if (rd_in) begin
         case (addr_in)
            ACS_OFF_CHSEL: rdata_next = chsel_reg;
            ACS_OFF_CFG: rdata_next = {div_reg, 3'h0};
            ACS_OFF_RESULT: rdata_next = result_reg;
            ACS_OFF_CTRL: rdata_next = {en_reg, lpt_reg, done_reg, busy_reg, 1'b0, src_reg};
            ACS_OFF_INT_STAT: begin
               rdata_next = istat_reg;
               istat_next = 8'h00;
            end
            ACS_OFF_INT_MASK: rdata_next = mask_reg;
            default: rdata_next = 8'h00;
         endcase
      end
      case (state_reg)
         ACS_ST_IDLE: begin
            if (start_ok) begin
               busy_next = 1'b1; // R6
               cnt_next = 5'h00;
               trk_next = 2'h0;
               bit_next = ACS_SAR_BITS_M1;
               trial_next = ACS_SAR_MSB;
               // The external edge already ends the low-input tracking window.
               if (lpt_reg && (src_reg != ACS_SRC_EXT)) begin
                  state_next = ACS_ST_TRACK; // R12
               end else begin
                  state_next = ACS_ST_CONV; // R13
               end
            end
         end
         ACS_ST_TRACK: begin
            if (tick) begin
               trk_next = trk_reg + 2'h1;
               if (trk_reg == ACS_TRACK_CLOCKS - 2'h1) begin
                  state_next = ACS_ST_CONV; // R12
               end
            end
         end
         ACS_ST_CONV: begin
            if (tick) begin
               bit_next = bit_reg - 3'h1;
               trial_next = code_final | ((bit_reg == 3'h0) ? 8'h00 : (8'h01 << (bit_reg - 3'h1)));
               if (bit_reg == 3'h0) begin
                  state_next = ACS_ST_IDLE;
                  busy_next = 1'b0; // R6
                  result_next = res_fmt; // R8
               end
            end
         end
         default: begin
            state_next = ACS_ST_IDLE;
            busy_next = 1'b0;
         end
      endcase
      if (done_evt) begin
         done_next = 1'b1; // R7
         istat_next[0] = 1'b1; // R7
      end
      // Disabling aborts a running conversion and raises no completion unless the last tick falls in the same cycle.
      if (!en_next) begin
         state_next = ACS_ST_IDLE; // R17
         busy_next = 1'b0;
      end
      irq_next = |(istat_next & mask_next); // R7
      if (!en_next || standby_in) begin
         track_next = 1'b0; // R17 R14
      end else if (lpt_next) begin
         track_next = (state_next == ACS_ST_TRACK)
            || ((state_next == ACS_ST_IDLE) && (src_next == ACS_SRC_EXT)
            && !ext_sync_reg); // R12 R13
      end else begin
         track_next = (state_next == ACS_ST_IDLE); // R11
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         chsel_reg <= ACS_CHSEL_RESET;
         div_reg <= ACS_DIV_RESET;
         cnt_reg <= 5'h00;
         en_reg <= 1'b0;
         lpt_reg <= 1'b0;
         done_reg <= 1'b0;
         busy_reg <= 1'b0;
         src_reg <= acs_src_t'(ACS_SRC_RESET);
         state_reg <= ACS_ST_IDLE;
         trk_reg <= 2'h0;
         bit_reg <= 3'h0;
         trial_reg <= 8'h00;
         result_reg <= 8'h00;
         istat_reg <= 8'h00;
         mask_reg <= ACS_MASK_RESET;
         rdata_out <= 8'h00;
         irq_out <= 1'b0;
         track_reg <= 1'b0;
         power_on_out <= 1'b0;
      end else begin
         chsel_reg <= chsel_next;
         div_reg <= div_next;
         cnt_reg <= cnt_next;
         en_reg <= en_next;
         lpt_reg <= lpt_next;
         done_reg <= done_next;
         busy_reg <= busy_next;
         src_reg <= src_next;
         state_reg <= state_next;
         trk_reg <= trk_next;
         bit_reg <= bit_next;
         trial_reg <= trial_next;
         result_reg <= result_next;
         istat_reg <= istat_next;
         mask_reg <= mask_next;
         rdata_out <= rdata_next;
         irq_out <= irq_next;
         track_reg <= track_next;
         power_on_out <= en_next; // R17
      end
   end

   assign track_out = track_reg;
   assign sar_trial_out = trial_reg;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   AST_SW_START: assert property ( // R3
      (start_ok && src_reg == ACS_SRC_SW) |=> busy_reg && state_reg != ACS_ST_IDLE)
      else $error("software start did not set busy");
   AST_T2_SOURCE: assert property ( // R10
      (state_reg == ACS_ST_IDLE && en_reg && src_reg == ACS_SRC_T2 && timer2_split_in
      && timer2_low_ovf_in && !wr_in) |=> busy_reg)
      else $error("timer 2 low overflow ignored in split mode");
   AST_EXT_EDGE: assert property ( // R5
      (state_reg == ACS_ST_IDLE && en_reg && src_reg == ACS_SRC_EXT && ext_rise && !wr_in)
      |=> busy_reg && state_reg == ACS_ST_CONV)
      else $error("external rising edge did not start a conversion");
   AST_IGNORE_BUSY: assert property ( // R19
      (state_reg == ACS_ST_CONV && start_evt && !done_evt && en_next)
      |=> state_reg == ACS_ST_CONV && bit_reg == $past(bit_reg) - 3'($past(tick) ? 1 : 0))
      else $error("start accepted during a conversion");
   AST_CONV_LEN: assert property (disable iff (rst_in || !en_reg) // R6
      (start_ok && !lpt_reg && div_reg == 5'h00) |=> busy_reg [*8] ##1 !busy_reg)
      else $error("conversion did not last eight conversion clocks");
   AST_TRACK_LEN: assert property (disable iff (rst_in || !en_reg) // R12
      (start_ok && lpt_reg && src_reg != ACS_SRC_EXT && div_reg == 5'h00)
      |=> (state_reg == ACS_ST_TRACK) [*3] ##1 state_reg == ACS_ST_CONV)
      else $error("low-power tracking was not three conversion clocks");
   AST_DONE_FALL: assert property ( // R7
      ($fell(busy_reg) && $past(en_next)) |-> done_reg && istat_reg[0])
      else $error("done flag not set on end of conversion");
   AST_RESULT: assert property ( // R8
      $rose(done_reg) |-> result_reg == $past(res_fmt))
      else $error("result not loaded with done flag");
   AST_DIVIDER: assert property ( // R1
      (state_reg == ACS_ST_CONV && cnt_reg == div_reg && bit_reg != 3'h0)
      |=> cnt_reg == 5'h00 && bit_reg == $past(bit_reg) - 3'h1)
      else $error("divider tick misplaced");
   AST_SHUTDOWN: assert property ( // R17
      !en_reg |-> !track_out && !busy_reg && !power_on_out)
      else $error("converter active while disabled");
   AST_IRQ: assert property ( // R7
      irq_out == |(istat_reg & mask_reg))
      else $error("interrupt output disagrees with status and mask");
   COV_SW_DONE: cover property (start_ok && src_reg == ACS_SRC_SW ##[1:300] $rose(done_reg));
   COV_LP_TRACK: cover property (state_reg == ACS_ST_TRACK ##1 state_reg == ACS_ST_CONV);
   COV_EXT: cover property (start_ok && src_reg == ACS_SRC_EXT);
   COV_IRQ: cover property ($rose(irq_out));
endmodule : acs_sequencer

//--- test/acs_far_model.sv
// Purpose: Comparator model that answers the sequencer's trial codes.
// Assumes: The bench holds the input level as a static offset-binary code.
// Notes: No settling is modelled, so the answer follows the trial code at once.
`timescale 1ns/1ps
module acs_far_model (
   input wire logic [7:0] trial_in,
   input wire logic [7:0] level_in,
   output logic compare_out
);
   import acs_pkg::*;
   // A level at or above the trial keeps the bit, as a real comparator does.
   assign compare_out = (level_in >= trial_in);
endmodule : acs_far_model

//--- test/testbench.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Register port strobes are one cycle except the held read in poll, driven after the rising edge.
// Notes: Busy time is measured by reading control back to back every cycle.
`timescale 1ns/1ps
module testbench;
   import acs_pkg::*;
   typedef struct {logic [2:0] src; logic [4:0] dv; logic lp; logic sp; logic [7:0] lv;
      logic [7:0] ch; logic [7:0] res;} acs_row_t;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr = 8'h00, wd = 8'h00, lvl = 8'h00, c, d, rdata, trial;
   logic wr = 1'b0, rd = 1'b0, t0 = 1'b0, t1 = 1'b0, t2l = 1'b0, t2h = 1'b0;
   logic sp = 1'b0, tsp = 1'b0, ext = 1'b0, sb = 1'b0, irq, trk, pwr, cmp;
   int bad_count = 0, n_checks = 0, ones, ex;
   acs_row_t rows [6];
   always #10 clk_in = ~clk_in;
   acs_sequencer dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wd),
      .wr_in(wr), .rd_in(rd), .timer0_ovf_in(t0), .timer1_ovf_in(t1),
      .timer2_low_ovf_in(t2l), .timer2_high_ovf_in(t2h), .timer2_split_in(tsp),
      .external_start_input(ext), .standby_in(sb), .compare_in(cmp), .rdata_out(rdata),
      .irq_out(irq), .track_out(trk), .power_on_out(pwr), .sar_trial_out(trial));
   acs_far_model fm (.trial_in(trial), .level_in(lvl), .compare_out(cmp));
   task end_sim();
      $display("Checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask : chk
   task wreg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_in);
      addr <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask : wreg
   task rreg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rreg
   // The start pulse or write lands on one edge; polling follows with no gap.
   task fire(input logic [2:0] s, input logic [7:0] cv);
      if (s == 3'h0) begin
         wreg(ACS_OFF_CTRL, cv | 8'h10);
      end else if (s == 3'h4) begin
         @(posedge clk_in);
         ext <= 1'b1;
      end else begin
         @(posedge clk_in);
         t0 <= (s == 3'h1);
         t1 <= (s == 3'h3);
         t2l <= (s == 3'h2) && sp;
         t2h <= (s == 3'h2) && !sp;
         @(posedge clk_in);
         {t0, t1, t2l, t2h} <= 4'h0;
      end
   endtask : fire
   task poll(output int n);
      int k;
      logic seen;
      n = 0;
      seen = 1'b0;
      addr <= ACS_OFF_CTRL;
      rd <= 1'b1;
      for (k = 0; k < 3000; k++) begin
         @(posedge clk_in);
         #1;
         if (rdata[ACS_CTRL_BUSY_BIT] === 1'b1) begin
            n++;
            seen = 1'b1;
         end else if (seen) begin
            break;
         end
      end
      rd <= 1'b0;
      if (k == 3000) begin
         bad_count++;
         end_sim();
      end
   endtask : poll
   initial begin
      rows[0] = '{3'h0, 5'h00, 1'b0, 1'b0, 8'h5A, 8'h00, 8'hDA};
      rows[1] = '{3'h1, 5'h03, 1'b1, 1'b0, 8'hFF, 8'h80, 8'hFF};
      rows[2] = '{3'h2, 5'h01, 1'b0, 1'b1, 8'h00, 8'h80, 8'h00};
      rows[3] = '{3'h2, 5'h00, 1'b1, 1'b0, 8'h80, 8'h10, 8'h00};
      rows[4] = '{3'h3, 5'h1F, 1'b0, 1'b0, 8'h01, 8'h90, 8'h01};
      rows[5] = '{3'h4, 5'h02, 1'b1, 1'b0, 8'h7F, 8'h00, 8'hFF};
      repeat (12) @(posedge clk_in);
      rst_in <= 1'b0;
      rreg(ACS_OFF_CTRL, d); chk("ctrl", 8'h00, d);
      rreg(ACS_OFF_CFG, d); chk("cfg", 8'hF8, d);
      rreg(ACS_OFF_CHSEL, d); chk("chsel", 8'h00, d);
      wreg(8'hAA, 8'h55);
      rreg(8'hAA, d); chk("unmapped", 8'h00, d);
      wreg(ACS_OFF_INT_MASK, 8'h01);
      foreach (rows[i]) begin
         c = 8'h80 | {1'b0, rows[i].lp, 3'b000, rows[i].src};
         sp <= rows[i].sp;
         tsp <= rows[i].sp;
         lvl <= rows[i].lv;
         wreg(ACS_OFF_CHSEL, rows[i].ch);
         wreg(ACS_OFF_CFG, {rows[i].dv, 3'b000});
         wreg(ACS_OFF_CTRL, c);
         fire(rows[i].src, c);
         poll(ones);
         ex = ((rows[i].lp && rows[i].src != 3'h4) ? 11 : 8) * (rows[i].dv + 1);
         n_checks++;
         if (ones != ex) begin
            $display("Error busy cycles expected %0d seen %0d", ex, ones);
            bad_count++;
         end
         chk("irq", 8'h01, {7'h00, irq});
         rreg(ACS_OFF_RESULT, d); chk("result", rows[i].res, d);
         rreg(ACS_OFF_CTRL, d); chk("ctrl done", c | 8'h20, d);
         rreg(ACS_OFF_INT_STAT, d); chk("status", 8'h01, d);
         chk("irq clear", 8'h00, {7'h00, irq});
         chk("track", {7'h00, !rows[i].lp}, {7'h00, trk});
         wreg(ACS_OFF_CTRL, c);
         ext <= 1'b0;
         repeat (5) @(posedge clk_in);
         if (rows[i].src == 3'h4) chk("track low pin", 8'h01, {7'h00, trk});
      end
      // A second overflow in mid-conversion must not restart it.
      wreg(ACS_OFF_CTRL, 8'h81);
      fire(3'h1, 8'h00);
      repeat (3) @(posedge clk_in);
      fire(3'h1, 8'h00);
      // Divider is still 2 from the last row; the second pulse lands 5 cycles in.
      poll(ones);
      n_checks++;
      if (ones != 8 * 3 - 5) begin
         $display("Error busy after second start expected %0d seen %0d", 8 * 3 - 5, ones);
         bad_count++;
      end
      rreg(ACS_OFF_CTRL, d); chk("no restart", 8'hA1, d);
      wreg(ACS_OFF_CTRL, 8'h81);
      fire(3'h2, 8'h00);
      fire(3'h3, 8'h00);
      fire(3'h0, 8'h81);
      tsp <= 1'b1;
      sp <= 1'b0;
      wreg(ACS_OFF_CTRL, 8'h82);
      fire(3'h2, 8'h00);
      rreg(ACS_OFF_CTRL, d); chk("wrong source", 8'h82, d);
      wreg(ACS_OFF_CTRL, 8'h00);
      fire(3'h0, 8'h00);
      rreg(ACS_OFF_CTRL, d); chk("disabled", 8'h00, d);
      chk("power", 8'h00, {7'h00, pwr});
      wreg(ACS_OFF_CTRL, 8'h80);
      repeat (2) @(posedge clk_in);
      chk("idle track", 8'h01, {7'h00, trk});
      chk("power on", 8'h01, {7'h00, pwr});
      sb <= 1'b1;
      repeat (3) @(posedge clk_in);
      chk("standby", 8'h00, {7'h00, trk});
      sb <= 1'b0;
      wreg(ACS_OFF_INT_MASK, 8'h00);
      fire(3'h0, 8'h80);
      poll(ones);
      chk("masked irq", 8'h00, {7'h00, irq});
      rreg(ACS_OFF_INT_STAT, d); chk("status set", 8'h01, d);
      rreg(ACS_OFF_INT_STAT, d); chk("status read clear", 8'h00, d);
      rst_in <= 1'b1;
      repeat (12) @(posedge clk_in);
      rst_in <= 1'b0;
      rreg(ACS_OFF_CTRL, d); chk("ctrl after reset", 8'h00, d);
      end_sim();
   end
endmodule : testbench
